// ==== design/ews_params.svh ====
// constants for the external wait-state and program paging block
`ifndef EWS_PARAMS_SVH
`define EWS_PARAMS_SVH

// ==========================================================
// memory-mapped register offsets in data space
`define EWS_PAGE_OFS 16'h001E
`define EWS_WAIT_OFS 16'h0028
`define EWS_CTRL_OFS 16'h002B

// ==========================================================
// reset values
`define EWS_WAIT_RST 16'h7FFF
`define EWS_CTRL_RST 1'h0
`define EWS_PAGE_RST 4'h0

// ==========================================================
// field positions in the wait count and control registers
`define EWS_IO_LSB 4'h9
`define EWS_IO_POS 12
`define EWS_DHI_POS 9
`define EWS_DLO_POS 6
`define EWS_PHI_POS 3
`define EWS_PLO_POS 0
`define EWS_XPA_POS 15
`define EWS_FLD_MSB 14
`define EWS_WAIT_MULTIPLIER_BIT_POS 0

// ==========================================================
// widths and address limits
`define EWS_FLD_W 3
`define EWS_CNT_W 4
`define EWS_PAGE_W 4
`define EWS_HALF_POS 15
`define EWS_OVL_TOP 16'h4000
`define EWS_DINT_TOP 16'h4000

`endif

// ==== design/ews_pkg.sv ====
// types shared by the wait-state and paging modules
package ews_pkg;

    // access space, one-hot
    typedef enum logic [2:0] {
        EWS_SP_PROG = 3'h1,
        EWS_SP_DATA = 3'h2,
        EWS_SP_IO = 3'h4
    } ews_space_e;

    // instruction classes seen by the page register; only the far ones load it
    typedef enum logic [3:0] {
        EWS_OP_OTHER = 4'h0,
        EWS_OP_FAR_BRANCH = 4'h1,
        EWS_OP_FAR_BRANCH_ACCUM = 4'h2,
        EWS_OP_FAR_CALL = 4'h3,
        EWS_OP_FAR_CALL_ACCUM = 4'h4,
        EWS_OP_FAR_RETURN = 4'h5,
        EWS_OP_FAR_RETURN_INT_ENABLE = 4'h6,
        EWS_OP_TABLE_READ = 4'h7,
        EWS_OP_TABLE_WRITE = 4'h8
    } ews_op_e;

    // bus cycle sequencer states
    typedef enum logic [2:0] {
        EWS_ST_IDLE = 3'h1,
        EWS_ST_WAIT = 3'h2,
        EWS_ST_END = 3'h4
    } ews_state_e;

    typedef struct packed {
        ews_state_e st;
        logic [3:0] page;
        logic [15:0] waits;
        logic wait_multiplier_bit;
        logic gen_en;
        logic rdy_s1;
        logic rdy_s2;
        logic [19:0] ext_addr;
        logic ext_cycle;
        ews_space_e ext_space;
        logic onchip;
        logic done;
        logic [15:0] rdata;
    } ews_top_s;

    typedef struct packed {
        logic [3:0] cnt;
    } ews_cnt_s;

endpackage : ews_pkg

// ==== design/ews_wait_if.sv ====
// link between the bus sequencer and its wait counter
`timescale 1ns/1ps
interface ews_wait_if;
    logic load;
    logic [3:0] count;
    logic enable;
    logic expired;

    modport ctl (output load, output count, output enable, input expired);
    modport cnt (input load, input count, input enable, output expired);
endinterface : ews_wait_if

// ==== design/ews_wait_counter.sv ====
// down counter that times the programmed wait states
`timescale 1ns/1ps
`include "ews_params.svh"
module ews_wait_counter (
    input wire logic clk,
    input wire logic rst,
    ews_wait_if.cnt wi
);
    import ews_pkg::*;

    ews_cnt_s r;
    ews_cnt_s n;

    // ======================================================
    // next count
    // with the generator clock off the count holds; all
    // fields are zero then, so a load of zero is all we see
    always_comb begin
        n = r;
        if (wi.load) begin
            n.cnt = wi.count;
        end else if (wi.enable && r.cnt != 4'h0) begin
            n.cnt = r.cnt - 4'h1;
        end
    end

    // expired only once the loaded count has run out
    assign wi.expired = !wi.load && r.cnt == 4'h0;

    // ======================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r.cnt <= 4'h0;
        end else begin
            r <= n;
        end
    end
endmodule : ews_wait_counter

// ==== design/ews_top.sv ====
// wait-state generator and program page register
`timescale 1ns/1ps
`include "ews_params.svh"
module ews_top (
    input wire logic clk,
    input wire logic rst,
    // memory-mapped register port from the core
    input wire logic mmr_wr,
    input wire logic mmr_rd,
    input wire logic [15:0] mmr_addr,
    input wire logic [15:0] mmr_wdata,
    // instruction class decoded by the core
    input wire logic op_valid,
    input wire ews_pkg::ews_op_e op_kind,
    input wire logic [19:0] op_target,
    // access request from the core
    input wire logic acc_req,
    input wire ews_pkg::ews_space_e acc_space,
    input wire logic [15:0] acc_addr,
    input wire logic acc_table,
    input wire logic [19:0] acc_long_addr,
    input wire logic ram_overlay_bit,
    // ready pin from external parts
    input wire logic ext_ready,
    // answers
    output logic [15:0] mmr_rdata,
    output logic [3:0] page,
    output logic [19:0] ext_addr,
    output logic ext_cycle,
    output ews_pkg::ews_space_e ext_space,
    output logic onchip,
    output logic acc_busy,
    output logic acc_done,
    output logic wait_clk_en
);
    import ews_pkg::*;

    ews_top_s r;
    ews_top_s n;
    ews_wait_if wi ();

    logic [2:0] base;
    logic [3:0] eff;
    logic [19:0] full_addr;
    logic is_int;
    logic finish;

    // ======================================================
    // wait counter
    ews_wait_counter u_cnt (
        .clk(clk),
        .rst(rst),
        .wi(wi.cnt)
    );

    // ======================================================
    // field selection for the current request
    // the field is picked from the request itself, so the
    // count is ready on the same edge the cycle starts
    always_comb begin
        base = r.waits[`EWS_PLO_POS +: `EWS_FLD_W];
        case (acc_space)
            EWS_SP_IO: begin
                base = r.waits[`EWS_IO_POS +: `EWS_FLD_W];
            end
            EWS_SP_DATA: begin
                if (acc_addr[`EWS_HALF_POS]) begin
                    base = r.waits[`EWS_DHI_POS +: `EWS_FLD_W];
                end else begin
                    base = r.waits[`EWS_DLO_POS +: `EWS_FLD_W];
                end
            end
            EWS_SP_PROG: begin
                // extended select folds both halves into one field
                if (!r.waits[`EWS_XPA_POS] && full_addr[`EWS_HALF_POS])
                begin
                    base = r.waits[`EWS_PHI_POS +: `EWS_FLD_W];
                end else begin
                    base = r.waits[`EWS_PLO_POS +: `EWS_FLD_W];
                end
            end
            default: begin
                base = r.waits[`EWS_PLO_POS +: `EWS_FLD_W];
            end
        endcase
    end

    // doubled base tops out at fourteen, fits four bits
    assign eff = r.wait_multiplier_bit ? {base, 1'b0} : {1'b0, base};

    // ======================================================
    // address forming and internal decode
    always_comb begin
        full_addr = {4'h0, acc_addr};
        is_int = 1'b0;
        case (acc_space)
            EWS_SP_PROG: begin
                if (acc_table) begin
                    full_addr = acc_long_addr;
                end else begin
                    full_addr = {r.page, acc_addr};
                end
                // overlay puts on-chip RAM in every page's low 16K
                is_int = ram_overlay_bit && full_addr[15:0] < `EWS_OVL_TOP;
            end
            EWS_SP_DATA: begin
                is_int = acc_addr < `EWS_DINT_TOP;
            end
            EWS_SP_IO: begin
                is_int = 1'b0;
            end
            default: begin
                is_int = 1'b0;
            end
        endcase
    end

    // cycle ends when the count ran out and the pin says ready
    assign finish = wi.expired && r.rdy_s2;

    // ======================================================
    // counter control
    always_comb begin
        wi.load = r.st == EWS_ST_IDLE && acc_req && !is_int;
        wi.count = eff;
        wi.enable = r.gen_en;
    end

    // ======================================================
    // next state
    always_comb begin
        n = r;
        n.done = 1'b0;
        // ready pin is asynchronous to us
        n.rdy_s1 = ext_ready;
        n.rdy_s2 = r.rdy_s1;

        // register writes from the core
        if (mmr_wr) begin
            case (mmr_addr)
                `EWS_PAGE_OFS: begin
                    n.page = mmr_wdata[`EWS_PAGE_W-1:0];
                end
                `EWS_WAIT_OFS: begin
                    n.waits = mmr_wdata;
                end
                `EWS_CTRL_OFS: begin
                    n.wait_multiplier_bit = mmr_wdata[`EWS_WAIT_MULTIPLIER_BIT_POS];
                end
                default: begin
                    n.wait_multiplier_bit = r.wait_multiplier_bit;
                end
            endcase
        end

        // generator clock follows the new fields, so an access right
        // after a write never meets a stopped counter
        n.gen_en = |n.waits[`EWS_FLD_MSB:0];

        // far ops win over a register write in the same cycle
        if (op_valid) begin
            case (op_kind)
                EWS_OP_FAR_BRANCH,
                EWS_OP_FAR_BRANCH_ACCUM,
                EWS_OP_FAR_CALL,
                EWS_OP_FAR_CALL_ACCUM,
                EWS_OP_FAR_RETURN,
                EWS_OP_FAR_RETURN_INT_ENABLE: begin
                    n.page = op_target[19:16];
                end
                default: begin
                    // table ops and all others keep the page
                    n.page = n.page;
                end
            endcase
        end

        // register reads, unmapped offsets answer zero
        if (mmr_rd) begin
            case (mmr_addr)
                `EWS_PAGE_OFS: begin
                    n.rdata = {12'h000, r.page};
                end
                `EWS_WAIT_OFS: begin
                    n.rdata = r.waits;
                end
                `EWS_CTRL_OFS: begin
                    n.rdata = {15'h0000, r.wait_multiplier_bit};
                end
                default: begin
                    n.rdata = 16'h0000;
                end
            endcase
        end

        // bus cycle sequencer
        case (r.st)
            EWS_ST_IDLE: begin
                if (acc_req) begin
                    n.ext_addr = full_addr;
                    n.ext_space = acc_space;
                    n.onchip = is_int;
                    if (is_int) begin
                        // on-chip targets need no waits
                        n.done = 1'b1;
                    end else begin
                        n.ext_cycle = 1'b1;
                        n.st = EWS_ST_WAIT;
                    end
                end
            end
            EWS_ST_WAIT: begin
                if (finish) begin
                    n.ext_cycle = 1'b0;
                    n.st = EWS_ST_END;
                    n.done = 1'b1;
                end
            end
            EWS_ST_END: begin
                // one idle cycle between external cycles
                n.st = EWS_ST_IDLE;
            end
            default: begin
                n.st = EWS_ST_IDLE;
                n.ext_cycle = 1'b0;
            end
        endcase
    end

    // ======================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r.st <= EWS_ST_IDLE;
            r.page <= `EWS_PAGE_RST;
            r.waits <= `EWS_WAIT_RST;
            r.wait_multiplier_bit <= `EWS_CTRL_RST;
            r.gen_en <= 1'b1;
            r.rdy_s1 <= 1'b0;
            r.rdy_s2 <= 1'b0;
            r.ext_addr <= 20'h00000;
            r.ext_cycle <= 1'b0;
            r.ext_space <= EWS_SP_PROG;
            r.onchip <= 1'b0;
            r.done <= 1'b0;
            r.rdata <= 16'h0000;
        end else begin
            r <= n;
        end
    end

    // ======================================================
    // outputs straight from the state register
    assign mmr_rdata = r.rdata;
    assign page = r.page;
    assign ext_addr = r.ext_addr;
    assign ext_cycle = r.ext_cycle;
    assign ext_space = r.ext_space;
    assign onchip = r.onchip;
    assign acc_busy = r.st != EWS_ST_IDLE;
    assign acc_done = r.done;
    assign wait_clk_en = r.gen_en;
endmodule : ews_top

// ==== test/ews_ext_part.sv ====
// external memory or port model that answers on the ready pin
`timescale 1ns/1ps
module ews_ext_part (
    input wire logic clk,
    input wire logic rst,
    input wire logic ext_cycle,
    input wire logic [3:0] lag,
    output logic ext_ready
);
    logic [3:0] cnt_r;
    // counts cycles of the current bus cycle; kept lag small, no wrap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt_r <= 4'h0;
        else cnt_r <= ext_cycle ? cnt_r + 4'h1 : 4'h0;
    end
    // lag 0 is a fast part tied ready; a slow part drops it when idle
    assign ext_ready = (lag == 4'h0) | (ext_cycle & (cnt_r >= lag));
endmodule : ews_ext_part

// ==== test/ews_top_properties.sv ====
// concurrent checks on the ports of the wait-state and paging top
`timescale 1ns/1ps
`include "ews_params.svh"
module ews_top_properties
    import ews_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic mmr_wr,
    input wire logic [15:0] mmr_addr,
    input wire logic [15:0] mmr_wdata,
    input wire logic op_valid,
    input wire ews_pkg::ews_op_e op_kind,
    input wire logic [19:0] op_target,
    input wire logic acc_req,
    input wire ews_pkg::ews_space_e acc_space,
    input wire logic [15:0] acc_addr,
    input wire logic acc_table,
    input wire logic [19:0] acc_long_addr,
    input wire logic ram_overlay_bit,
    input wire logic ext_ready,
    input wire logic [3:0] page,
    input wire logic [19:0] ext_addr,
    input wire logic ext_cycle,
    input wire logic onchip,
    input wire logic acc_busy,
    input wire logic acc_done,
    input wire logic wait_clk_en
);
    logic far, pw, ww, prg;
    // far codes form one contiguous run, so a range test is enough
    assign far = op_valid && op_kind >= EWS_OP_FAR_BRANCH
        && op_kind <= EWS_OP_FAR_RETURN_INT_ENABLE;
    assign pw = mmr_wr && mmr_addr == `EWS_PAGE_OFS;
    assign ww = mmr_wr && mmr_addr == `EWS_WAIT_OFS;
    assign prg = acc_req && !acc_busy && acc_space == EWS_SP_PROG;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // page register and address forming
    chk_far_load: assert property (
        far |=> page == $past(op_target[19:16])) else $error("far op page");
    chk_page_kept: assert property (
        !far && !pw |=> $stable(page)) else $error("page moved");
    chk_prog_addr: assert property (
        prg && !acc_table |=> ext_addr == {$past(page), $past(acc_addr)})
        else $error("program address");
    chk_table_addr: assert property (
        prg && acc_table |=> ext_addr == $past(acc_long_addr))
        else $error("table address");
    chk_overlay_ram: assert property (
        prg && !acc_table && ram_overlay_bit && acc_addr < `EWS_OVL_TOP
        |=> onchip && !ext_cycle) else $error("overlay not internal");

    // ==========================================================
    // bus cycle timing
    chk_ready_holds: assert property (
        ext_cycle && !ext_ready && !$past(ext_ready) ##1 ext_cycle
        |=> ext_cycle [*2]) else $error("ended without ready");
    chk_clock_gate: assert property (
        ww ##1 !ww |=> wait_clk_en
        == (($past(mmr_wdata, 2) & 16'h7FFF) != 16'h0))
        else $error("wait clock enable");
    chk_done_at_end: assert property (
        $fell(ext_cycle) |-> acc_done) else $error("no done pulse");
endmodule : ews_top_properties

bind ews_top ews_top_properties chk_u (.clk(clk), .rst(rst),
    .mmr_wr(mmr_wr), .mmr_addr(mmr_addr), .mmr_wdata(mmr_wdata),
    .op_valid(op_valid), .op_kind(op_kind), .op_target(op_target),
    .acc_req(acc_req), .acc_space(acc_space), .acc_addr(acc_addr),
    .acc_table(acc_table), .acc_long_addr(acc_long_addr), .ram_overlay_bit(ram_overlay_bit),
    .ext_ready(ext_ready), .page(page), .ext_addr(ext_addr),
    .ext_cycle(ext_cycle), .onchip(onchip), .acc_busy(acc_busy),
    .acc_done(acc_done), .wait_clk_en(wait_clk_en));

// ==== test/ews_top_bench.sv ====
// self-checking bench for the wait-state and paging block
`timescale 1ns/1ps
`include "ews_params.svh"
module ews_top_bench;
    import ews_pkg::*;
    logic clk, rst, mmr_wr, mmr_rd, op_valid, acc_req, acc_table, ram_overlay_bit;
    logic [15:0] mmr_addr, mmr_wdata, acc_addr, mmr_rdata, a;
    logic [19:0] op_target, acc_long_addr, ext_addr;
    logic [3:0] page, lag;
    logic ext_ready, ext_cycle, onchip, acc_busy, acc_done, wait_clk_en;
    logic [31:0] rs;
    ews_op_e op_kind;
    ews_space_e acc_space, ext_space;
    int num_errors, samples_checked, wr_m, sw_m, pg_m, i, k;

    ews_top dut_u (.clk(clk), .rst(rst), .mmr_wr(mmr_wr), .mmr_rd(mmr_rd),
        .mmr_addr(mmr_addr), .mmr_wdata(mmr_wdata), .op_valid(op_valid),
        .op_kind(op_kind), .op_target(op_target), .acc_req(acc_req),
        .acc_space(acc_space), .acc_addr(acc_addr), .acc_table(acc_table),
        .acc_long_addr(acc_long_addr), .ram_overlay_bit(ram_overlay_bit), .ext_ready(ext_ready),
        .mmr_rdata(mmr_rdata), .page(page), .ext_addr(ext_addr),
        .ext_cycle(ext_cycle), .ext_space(ext_space), .onchip(onchip),
        .acc_busy(acc_busy), .acc_done(acc_done), .wait_clk_en(wait_clk_en));
    ews_ext_part part_u (.clk(clk), .rst(rst), .ext_cycle(ext_cycle),
        .lag(lag), .ext_ready(ext_ready));

    always #50 clk = ~clk;

    // ==========================================================
    // helpers and reference model
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // field pick: io, upper or lower data, program split by bit 15
    function automatic int expect_waits(input ews_space_e sp,
        input logic [15:0] ad);
        int f;
        if (sp == EWS_SP_IO) f = 12;
        else if (sp == EWS_SP_DATA) f = ad[15] ? 9 : 6;
        else f = (wr_m[15] == 0 && ad[15]) ? 3 : 0;
        return ((wr_m >> f) & 7) * (sw_m + 1);
    endfunction : expect_waits
    task automatic step;
        @(posedge clk);
        #10;
    endtask : step
    task automatic check(input string nm, input logic [19:0] seen,
        input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    task automatic mmr_write(input logic [15:0] ad, input logic [15:0] d);
        step();
        mmr_wr = 1'b1;
        mmr_addr = ad;
        mmr_wdata = d;
        step();
        mmr_wr = 1'b0;
        if (ad == `EWS_WAIT_OFS) wr_m = d;
        if (ad == `EWS_CTRL_OFS) sw_m = d[0];
        if (ad == `EWS_PAGE_OFS) pg_m = d[3:0];
    endtask : mmr_write
    task automatic mmr_read(input logic [15:0] ad, input logic [15:0] e);
        step();
        mmr_rd = 1'b1;
        mmr_addr = ad;
        step();
        mmr_rd = 1'b0;
        check("register", mmr_rdata, e);
    endtask : mmr_read
    task automatic op_do(input int kd, input logic [19:0] tg);
        step();
        op_valid = 1'b1;
        op_kind = ews_op_e'(kd);
        op_target = tg;
        step();
        op_valid = 1'b0;
        if (kd >= 1 && kd <= 6) pg_m = tg[19:16];
        check("page", page, pg_m);
    endtask : op_do
    // one access; the part's lag settles through the ready synchroniser
    task automatic access(input ews_space_e sp, input logic [15:0] ad,
        input logic t, input logic [19:0] la, input int lv, input logic ex);
        int n, w;
        w = expect_waits(sp, t ? la[15:0] : ad);
        lag = lv[3:0];
        repeat (3) step();
        acc_req = 1'b1;
        acc_space = sp;
        acc_addr = ad;
        acc_table = t;
        acc_long_addr = la;
        step();
        acc_req = 1'b0;
        check("busy", acc_busy, ex);
        n = 0;
        while (ext_cycle === 1'b1 && n < 200) begin
            step();
            n++;
        end
        if (lv == 0) check("length", n, ex ? w + 1 : 0);
        else check("stretch", n >= lv + 2 && n >= w + 1 && n <= lv + w + 4,
            1);
        check("done", acc_done, 1'b1);
        check("onchip", onchip, !ex);
        check("space", ext_space, sp);
        if (sp == EWS_SP_PROG) check("address", ext_addr,
            t ? la : {pg_m[3:0], ad});
        step();
    endtask : access
    task automatic tally_and_finish;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // main sequence
    initial begin
        {clk, mmr_wr, mmr_rd, op_valid, acc_req, acc_table, ram_overlay_bit} = 7'h00;
        {mmr_addr, mmr_wdata, acc_addr, op_target, acc_long_addr} = 0;
        op_kind = EWS_OP_OTHER;
        acc_space = EWS_SP_PROG;
        lag = 4'h0;
        rs = 32'h1BD3;
        {num_errors, samples_checked, sw_m, pg_m} = 0;
        wr_m = 16'h7FFF;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #10 rst = 1'b0;
        mmr_read(`EWS_WAIT_OFS, 16'h7FFF);
        mmr_read(`EWS_PAGE_OFS, 16'h0000);
        mmr_read(`EWS_CTRL_OFS, 16'h0000);
        mmr_read(16'h0030, 16'h0000);
        check("gate", wait_clk_en, 1'b1);
        access(EWS_SP_IO, 16'hFFFF, 0, 0, 0, 1);
        for (k = 0; k < 9; k++) begin
            rs = lfsr(rs);
            op_do(k, rs[19:0]);
        end
        mmr_write(`EWS_PAGE_OFS, 16'hFFF5);
        mmr_read(`EWS_PAGE_OFS, 16'h0005);
        // every field, both range modes and both multipliers
        for (i = 0; i < 8; i++) begin
            rs = lfsr(rs);
            mmr_write(`EWS_WAIT_OFS, {i[0], rs[14:0]});
            mmr_write(`EWS_CTRL_OFS, {rs[31:17], i[1]});
            mmr_read(`EWS_CTRL_OFS, {15'h0000, i[1]});
            for (k = 0; k < 6; k++) begin
                rs = lfsr(rs);
                a = rs[15:0] | 16'h4000;
                if (k == 1 || k == 3) a[15] = 1'b1;
                if (k == 2 || k == 4) a[15] = 1'b0;
                access(k == 0 ? EWS_SP_IO : k < 3 ? EWS_SP_DATA : EWS_SP_PROG,
                    a, k == 5, {rs[19:16], a}, 0, 1);
            end
        end
        mmr_write(`EWS_WAIT_OFS, 16'h8000);
        step();
        check("gate", wait_clk_en, 1'b0);
        access(EWS_SP_DATA, 16'h8001, 0, 0, 5, 1);
        mmr_write(`EWS_WAIT_OFS, 16'h0E49);
        access(EWS_SP_DATA, 16'h9000, 0, 0, 3, 1);
        ram_overlay_bit = 1'b1;
        access(EWS_SP_PROG, 16'h2000, 0, 0, 0, 0);
        ram_overlay_bit = 1'b0;
        access(EWS_SP_PROG, 16'h2000, 0, 0, 0, 1);
        tally_and_finish();
    end

    // hang guard, well beyond the thousand or so cycles the run needs
    initial begin
        #2000000;
        num_errors++;
        tally_and_finish();
    end
endmodule : ews_top_bench
